//--- verilog/xfer_vector_engine.sv
`timescale 1ns/1ps
// How it works
// - Software vector address is 0x0400 plus field times two.
// - Read vector pointer, then fetch descriptor there.
// - Vector entry is two bytes, low pointer bits.
// - External lines and byte-timer matches use fixed vectors.
// - Conversion done uses vector 28, enable B6.
// - Timer-unit matches use vectors 32-35, 40-41, 44-45.
// - Serial requests use vectors 81/82, 85/86, 89/90.
// - Software first, then ascending vector number.
// - Descriptor order: mode A, source, mode B, destination, counts.
// - Chained descriptors follow back to back.
// - Each normal-mode service moves one byte or word.
// - Count allows 1 to 65,536 transfers.
// - Finished count may raise a CPU interrupt.
// - Count word A counts, count word B ignored.
// - Source word reads, destination word writes.
// - Pointers 24 bits, each steps up, down or holds.
// - Step is 1 for bytes, 2 for words.
// - Source end or select: clear enable, keep flag; else reverse. Software clears its enable only when neither.
module xfer_vector_engine
   import xfer_vec_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rstn,
   // Register port
   input  wire logic [2:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // Activation sources
   input  wire logic [NSRC-1:0]   src_req,
   output logic [NSRC-1:0]        src_flag_clr,
   // CPU interrupt request
   output logic                   cpu_irq,
   output logic                   cpu_irq_sw,
   output logic [4:0]             cpu_irq_src,
   // Memory master
   output mem_cmd_t               mem_cmd,
   input  wire logic              mem_ack,
   input  wire logic [31:0]       mem_rdata
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   state_t          state_q;
   mem_cmd_t        cmd_q;
   desc_t           desc_q;
   logic [23:0]     ptr_q;
   logic [1:0]      widx_q;
   logic [31:0]     data_q;
   logic            act_sw_q;
   logic [4:0]      act_idx_q;
   logic [6:0]      sw_vec_q;
   logic            sw_en_q;
   logic [47:0]     en_q;
   logic [7:0]      rdata_q;
   logic [NSRC-1:0] flag_clr_q;
   logic            irq_q;
   logic            irq_sw_q;
   logic [4:0]      irq_src_q;

   // ---------------------------------------------------------------
   // Activation and arbitration
   // ---------------------------------------------------------------
   logic [NSRC-1:0] pend;
   logic            grant_valid;
   logic            grant_sw;
   logic [4:0]      grant_idx;
   logic [15:0]     vec_addr;

   // A flag being cleared still reads high for one cycle, so it is masked to stop a second service.
   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         pend[i] = src_req[i] & en_q[SRC_EN_POS[i]] & ~flag_clr_q[i];
      end
   end

   src_arbiter #(
      .N (NSRC)
   ) u_arb (
      .sw_req      (sw_en_q),
      .req         (pend),
      .grant_valid (grant_valid),
      .grant_sw    (grant_sw),
      .grant_idx   (grant_idx)
   );

   // Vector entries are two bytes apart.
   always_comb begin
      if (grant_sw) begin
         vec_addr = VEC_BASE + {8'h00, sw_vec_q, 1'b0};
      end else begin
         vec_addr = VEC_BASE + {8'h00, SRC_VEC[grant_idx], 1'b0};
      end
   end

   // ---------------------------------------------------------------
   // Transfer arithmetic
   // ---------------------------------------------------------------
   function automatic logic [23:0] step_ptr(input logic [1:0] mode, input logic [23:0] a, input logic word);
      logic [23:0] inc;
      inc = word ? 24'h000002 : 24'h000001;
      case (mode)
         STEP_INC: step_ptr = a + inc;
         STEP_DEC: step_ptr = a - inc;
         default:  step_ptr = a;
      endcase
   endfunction

   logic        is_word;
   logic [23:0] src_nx;
   logic [23:0] dst_nx;
   logic [15:0] cnt_nx;
   logic        wb_last;
   logic        finish;
   logic        ended;
   logic        per_transfer_interrupt_select;

   assign is_word = desc_q.mode_a[MA_SIZE];
   assign src_nx  = step_ptr(desc_q.mode_a[MA_SRC_LO+:2], desc_q.src, is_word);
   assign dst_nx  = step_ptr(desc_q.mode_a[MA_DST_LO+:2], desc_q.dst, is_word);
   // A count of zero wraps to 0xFFFF, so it runs the full 65,536 transfers.
   assign cnt_nx  = desc_q.count_a - 16'h0001;
   assign wb_last = (state_q == ST_WB) && mem_ack && (widx_q == DESC_LAST);
   assign finish  = wb_last && !desc_q.mode_b[MB_CHAIN];
   assign ended   = (desc_q.count_a == 16'h0000);
   assign per_transfer_interrupt_select   = desc_q.mode_b[MB_PER_TRANSFER_INTERRUPT_SELECT];

   // ---------------------------------------------------------------
   // Sequencer and memory command
   // ---------------------------------------------------------------
   // The command stands until acknowledged; an ack completes the command presented in that cycle.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q   <= ST_IDLE;
         cmd_q     <= '0;
         ptr_q     <= 24'h000000;
         widx_q    <= 2'h0;
         act_sw_q  <= 1'b0;
         act_idx_q <= 5'h00;
      end else begin
         case (state_q)
            ST_IDLE: begin
               cmd_q <= '0;
               if (grant_valid) begin
                  act_sw_q  <= grant_sw;
                  act_idx_q <= grant_idx;
                  cmd_q     <= '{req: 1'b1, we: 1'b0, word: 1'b1, addr: {8'h00, vec_addr}, wdata: 32'h0};
                  state_q   <= ST_VEC_RD;
               end
            end
            ST_VEC_RD: begin
               if (mem_ack) begin
                  ptr_q      <= {RAM_HI, mem_rdata[15:0]};
                  cmd_q.addr <= {RAM_HI, mem_rdata[15:0]};
                  cmd_q.word <= 1'b0;
                  widx_q     <= 2'h0;
                  state_q    <= ST_DESC_RD;
               end
            end
            ST_DESC_RD: begin
               if (mem_ack) begin
                  widx_q <= widx_q + 2'h1;
                  if (widx_q == DESC_LAST) begin
                     cmd_q.addr <= desc_q.src;
                     cmd_q.word <= is_word;
                     state_q    <= ST_DATA_RD;
                  end else begin
                     cmd_q.addr <= cmd_q.addr + DESC_WORD;
                  end
               end
            end
            ST_DATA_RD: begin
               if (mem_ack) begin
                  cmd_q.we    <= 1'b1;
                  cmd_q.addr  <= desc_q.dst;
                  cmd_q.wdata <= mem_rdata;
                  state_q     <= ST_DATA_WR;
               end
            end
            ST_DATA_WR: begin
               if (mem_ack) begin
                  cmd_q.word  <= 1'b0;
                  cmd_q.addr  <= ptr_q;
                  cmd_q.wdata <= {desc_q.mode_a, src_nx};
                  widx_q      <= 2'h0;
                  state_q     <= ST_WB;
               end
            end
            ST_WB: begin
               if (mem_ack) begin
                  widx_q <= widx_q + 2'h1;
                  if (widx_q == 2'h0) begin
                     cmd_q.addr  <= cmd_q.addr + DESC_WORD;
                     cmd_q.wdata <= {desc_q.mode_b, desc_q.dst};
                  end else if (widx_q == 2'h1) begin
                     cmd_q.addr  <= cmd_q.addr + DESC_WORD;
                     cmd_q.wdata <= {desc_q.count_a, desc_q.count_b};
                  end else if (desc_q.mode_b[MB_CHAIN]) begin
                     ptr_q      <= ptr_q + DESC_STRIDE;
                     cmd_q      <= '{req: 1'b1, we: 1'b0, word: 1'b0, addr: ptr_q + DESC_STRIDE, wdata: 32'h0};
                     widx_q     <= 2'h0;
                     state_q    <= ST_DESC_RD;
                  end else begin
                     cmd_q   <= '0;
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               cmd_q   <= '0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Descriptor and data holding
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         desc_q <= '0;
         data_q <= 32'h0;
      end else if (state_q == ST_DESC_RD && mem_ack) begin
         case (widx_q)
            2'h0:    {desc_q.mode_a, desc_q.src}      <= mem_rdata;
            2'h1:    {desc_q.mode_b, desc_q.dst}      <= mem_rdata;
            default: {desc_q.count_a, desc_q.count_b} <= mem_rdata;
         endcase
      end else if (state_q == ST_DATA_RD && mem_ack) begin
         data_q <= mem_rdata;
      end else if (state_q == ST_DATA_WR && mem_ack) begin
         desc_q.src     <= src_nx;
         desc_q.dst     <= dst_nx;
         desc_q.count_a <= cnt_nx;
      end
   end

   // ---------------------------------------------------------------
   // Enable registers and completion effects
   // ---------------------------------------------------------------
   // A register write in the same cycle as a completion keeps the written value.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sw_vec_q <= SWVEC_RST[6:0];
         sw_en_q  <= SWVEC_RST[SWV_EN_BIT];
         en_q     <= {EN_GROUPS{EN_RST}};
      end else begin
         if (reg_wr && reg_addr == REG_SWVEC) begin
            sw_vec_q <= reg_wdata[6:0];
            sw_en_q  <= reg_wdata[SWV_EN_BIT];
         end else if (finish && act_sw_q && !(ended || per_transfer_interrupt_select)) begin
            sw_en_q <= 1'b0;
         end
         for (int g = 0; g < EN_GROUPS; g++) begin
            if (reg_wr && reg_addr == REG_EN_A + 3'(g)) begin
               en_q[g*8+:8] <= reg_wdata;
            end else if (finish && !act_sw_q && (ended || per_transfer_interrupt_select) && SRC_EN_POS[act_idx_q][5:3] == 3'(g)) begin
               en_q[SRC_EN_POS[act_idx_q]] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flag_clr_q <= '0;
         irq_q      <= 1'b0;
         irq_sw_q   <= 1'b0;
         irq_src_q  <= 5'h00;
      end else begin
         flag_clr_q <= '0;
         irq_q      <= 1'b0;
         if (finish && (ended || per_transfer_interrupt_select)) begin
            irq_q     <= 1'b1;
            irq_sw_q  <= act_sw_q;
            irq_src_q <= act_idx_q;
         end else if (finish && !act_sw_q) begin
            flag_clr_q[act_idx_q] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == REG_SWVEC) begin
            rdata_q <= {sw_en_q, sw_vec_q};
         end else if (reg_addr == REG_STATUS) begin
            rdata_q <= {(state_q != ST_IDLE), 4'h0, state_q};
         end else if (reg_addr >= REG_EN_A && reg_addr <= REG_EN_F) begin
            rdata_q <= en_q[(reg_addr - REG_EN_A)*8+:8];
         end else begin
            rdata_q <= 8'h00;
         end
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata    = rdata_q;
   assign src_flag_clr = flag_clr_q;
   assign cpu_irq      = irq_q;
   assign cpu_irq_sw   = irq_sw_q;
   assign cpu_irq_src  = irq_src_q;
   assign mem_cmd      = cmd_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_start;
      state_q == ST_IDLE && grant_valid;
   endsequence
   sequence s_data_wr_done;
      state_q == ST_DATA_WR && mem_ack;
   endsequence

   AST_SW_VEC_ADDR: assert property (s_start and grant_sw |=> cmd_q.addr == {8'h00, VEC_BASE} + {16'h0, $past(sw_vec_q), 1'b0})
      else $error("software vector address wrong");
   AST_SRC_VEC_ADDR: assert property (s_start and !grant_sw |=>
         cmd_q.addr[15:0] == VEC_BASE + {8'h00, SRC_VEC[act_idx_q], 1'b0} && cmd_q.req && !cmd_q.we)
      else $error("source vector address wrong");
   AST_SW_FIRST: assert property (state_q == ST_IDLE && sw_en_q |=> act_sw_q)
      else $error("software activation not served first");
   AST_PTR_FROM_VEC: assert property (state_q == ST_VEC_RD && mem_ack |=>
         state_q == ST_DESC_RD && cmd_q.addr == {RAM_HI, $past(mem_rdata[15:0])})
      else $error("descriptor not fetched from vector pointer");
   AST_DESC_ORDER: assert property (state_q == ST_DESC_RD && mem_ack && widx_q != DESC_LAST |=>
         cmd_q.addr == $past(cmd_q.addr) + DESC_WORD ##0 state_q == ST_DESC_RD)
      else $error("descriptor words out of order");
   AST_CHAIN_NEXT: assert property (wb_last && desc_q.mode_b[MB_CHAIN] |=>
         state_q == ST_DESC_RD && cmd_q.addr == $past(ptr_q) + DESC_STRIDE && widx_q == 2'h0)
      else $error("chained descriptor not contiguous");
   AST_ONE_UNIT: assert property (state_q == ST_DATA_RD && mem_ack |=>
         state_q == ST_DATA_WR && cmd_q.we && cmd_q.addr == $past(desc_q.dst) ##1 state_q != ST_DATA_RD)
      else $error("data write not to destination");
   AST_SRC_STEP: assert property (s_data_wr_done and desc_q.mode_a[MA_SRC_LO+:2] == STEP_INC |=>
         desc_q.src == $past(desc_q.src) + ($past(is_word) ? 24'h000002 : 24'h000001))
      else $error("source step wrong");
   AST_COUNT_DEC: assert property (s_data_wr_done |=> desc_q.count_a == $past(desc_q.count_a) - 16'h0001)
      else $error("count not decremented");
   AST_END_IRQ: assert property (finish && ended && !act_sw_q |=> cpu_irq && src_flag_clr == '0)
      else $error("end of count handling wrong");

endmodule

//--- verilog/xfer_vec_pkg.sv
package xfer_vec_pkg;

   // ---------------------------------------------------------------
   // Register map and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] REG_SWVEC   = 3'h0;
   localparam logic [2:0] REG_EN_A    = 3'h1;
   localparam logic [2:0] REG_EN_F    = 3'h6;
   localparam logic [2:0] REG_STATUS  = 3'h7;
   localparam logic [7:0] SWVEC_RST   = 8'h00;
   localparam logic [7:0] EN_RST      = 8'h00;
   localparam int         SWV_EN_BIT  = 7;
   localparam int         EN_GROUPS   = 6;

   // ---------------------------------------------------------------
   // Vector table, descriptor layout and memory map
   // ---------------------------------------------------------------
   localparam logic [15:0] VEC_BASE    = 16'h0400;
   localparam logic [7:0]  RAM_HI      = 8'hFF;
   localparam logic [23:0] DESC_WORD   = 24'h000004;
   localparam logic [23:0] DESC_STRIDE = 24'h00000C;
   localparam logic [1:0]  DESC_LAST   = 2'h2;
   localparam int          NSRC        = 27;

   // Mode word A: [7:6] source step, [5:4] destination step, [0] word size.
   localparam int         MA_SRC_LO  = 6;
   localparam int         MA_DST_LO  = 4;
   localparam int         MA_SIZE    = 0;
   // Mode word B: [7] chain flag, [6] per-transfer interrupt select.
   localparam int         MB_CHAIN   = 7;
   localparam int         MB_PER_TRANSFER_INTERRUPT_SELECT   = 6;
   localparam logic [1:0] STEP_INC   = 2'h2;
   localparam logic [1:0] STEP_DEC   = 2'h3;

   // Sources in ascending vector order, with their enable bit position (group*8+bit).
   localparam logic [6:0] SRC_VEC [0:NSRC-1] = '{
      7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h1C,
      7'h20, 7'h21, 7'h22, 7'h23, 7'h28, 7'h29, 7'h2C, 7'h2D,
      7'h40, 7'h41, 7'h44, 7'h45, 7'h51, 7'h52, 7'h55, 7'h56, 7'h59, 7'h5A};
   localparam logic [5:0] SRC_EN_POS [0:NSRC-1] = '{
      6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00, 6'h0E,
      6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h09, 6'h08, 6'h17, 6'h16,
      6'h1B, 6'h1A, 6'h19, 6'h18, 6'h23, 6'h22, 6'h21, 6'h20, 6'h2F, 6'h2E};

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        req;
      logic        we;
      logic        word;
      logic [23:0] addr;
      logic [31:0] wdata;
   } mem_cmd_t;

   typedef struct packed {
      logic [7:0]  mode_a;
      logic [23:0] src;
      logic [7:0]  mode_b;
      logic [23:0] dst;
      logic [15:0] count_a;
      logic [15:0] count_b;
   } desc_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_VEC_RD  = 3'b001,
      ST_DESC_RD = 3'b010,
      ST_DATA_RD = 3'b011,
      ST_DATA_WR = 3'b100,
      ST_WB      = 3'b101
   } state_t;

endpackage

//--- verilog/src_arbiter.sv
`timescale 1ns/1ps
module src_arbiter
   import xfer_vec_pkg::*;
#(
   parameter int N = NSRC
) (
   // Requests
   input  wire logic         sw_req,
   input  wire logic [N-1:0] req,
   // Grant
   output logic              grant_valid,
   output logic              grant_sw,
   output logic [4:0]        grant_idx
);

   // Software first, then the lowest index, which is the lowest vector number.
   always_comb begin
      grant_valid = sw_req | (|req);
      grant_sw    = sw_req;
      grant_idx   = 5'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            grant_idx = 5'(i);
         end
      end
   end

endmodule

//--- tb/periph_mem_model.sv
`timescale 1ns/1ps
module periph_mem_model
   import xfer_vec_pkg::*;
(
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            rstn,
   // Memory slave
   input  wire mem_cmd_t        mem_cmd,
   output logic                 mem_ack,
   output logic [31:0]          mem_rdata,
   // Source flags
   input  wire logic [NSRC-1:0] flag_set,
   input  wire logic [NSRC-1:0] src_flag_clr,
   output logic [NSRC-1:0]      src_req
);
   logic [7:0]  mem [int];
   logic [1:0]  wait_q;
   logic [31:0] junk_q;
   logic [2:0]  nb;
   logic [31:0] rd;

   function automatic logic [7:0] rb(input int a);
      return mem.exists(a) ? mem[a] : 8'hA5;
   endfunction

   // Descriptors sit aligned in the RAM window and data is kept outside it, so the address gives the size.
   always_comb begin
      if (mem_cmd.addr >= 24'hFFF800 && mem_cmd.addr <= 24'hFFFBFF && mem_cmd.addr[1:0] == 2'h0) begin
         nb = 3'h4;
      end else begin
         nb = mem_cmd.word ? 3'h2 : 3'h1;
      end
   end

   assign rd        = {rb(int'(mem_cmd.addr) + 3), rb(int'(mem_cmd.addr) + 2),
                       rb(int'(mem_cmd.addr) + 1), rb(int'(mem_cmd.addr))};
   assign mem_ack   = mem_cmd.req && wait_q == 2'h0;
   // Outside an acknowledge the data lines wander, so a stale value is never mistaken for an answer.
   assign mem_rdata = mem_ack ? rd : ~junk_q;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wait_q  <= 2'h0;
         junk_q  <= 32'h0;
         src_req <= '0;
      end else begin
         junk_q  <= junk_q + 32'h9E3779B9;
         src_req <= (src_req & ~src_flag_clr) | flag_set;
         if (mem_cmd.req) begin
            wait_q <= mem_ack ? 2'($urandom_range(2)) : wait_q - 2'h1;
         end
      end
   end

   always @(posedge core_clk) begin
      if (mem_ack && mem_cmd.we) begin
         for (int k = 0; k < int'(nb); k++) begin
            mem[int'(mem_cmd.addr) + k] = mem_cmd.wdata[8*k +: 8];
         end
      end
   end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import xfer_vec_pkg::*;

   typedef struct packed {
      logic        we;
      logic [23:0] addr;
      logic [31:0] data;
      logic [31:0] mask;
   } exp_cmd_t;

   logic            core_clk;
   logic            rstn;
   logic [2:0]      reg_addr;
   logic [7:0]      reg_wdata;
   logic            reg_wr;
   logic            reg_rd;
   logic [7:0]      reg_rdata;
   logic [NSRC-1:0] src_req;
   logic [NSRC-1:0] src_flag_clr;
   logic [NSRC-1:0] flag_set;
   logic            cpu_irq;
   logic            cpu_irq_sw;
   logic [4:0]      cpu_irq_src;
   mem_cmd_t        mem_cmd;
   logic            mem_ack;
   logic [31:0]     mem_rdata;
   int              failures;
   int              checks;
   int              cyc;
   logic            rd_d;
   logic            cmd_on;
   exp_cmd_t        e_c;
   logic [33:0]     e_v;
   exp_cmd_t        cmd_q [$];
   logic [33:0]     ev_q [$];
   logic [7:0]      rd_q [$];
   int              vec_num [NSRC] = '{16, 17, 18, 19, 20, 21, 22, 23, 28, 32, 33, 34, 35, 40, 41, 44, 45,
                                       64, 65, 68, 69, 81, 82, 85, 86, 89, 90};
   int              en_pos [NSRC]  = '{7, 6, 5, 4, 3, 2, 1, 0, 14, 13, 12, 11, 10, 9, 8, 23, 22,
                                       27, 26, 25, 24, 35, 34, 33, 32, 47, 46};

   xfer_vector_engine dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .src_flag_clr(src_flag_clr),
      .cpu_irq(cpu_irq), .cpu_irq_sw(cpu_irq_sw), .cpu_irq_src(cpu_irq_src), .mem_cmd(mem_cmd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   periph_mem_model u_mem (.core_clk(core_clk), .rstn(rstn), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .flag_set(flag_set), .src_flag_clr(src_flag_clr), .src_req(src_req));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      rd_d <= reg_rd && rstn;
      if (rd_d) check("reg_rdata", 64'(reg_rdata), 64'(rd_q.size() ? rd_q.pop_front() : 8'hXX));
      if (rstn && cmd_on && mem_cmd.req && mem_ack) begin
         e_c = cmd_q.size() ? cmd_q.pop_front() : 'x;
         check("mem_cmd", {mem_cmd.we, mem_cmd.addr, mem_cmd.wdata & e_c.mask}, {e_c.we, e_c.addr, e_c.data});
      end
      if (rstn && (cpu_irq || |src_flag_clr)) begin
         e_v = ev_q.size() ? ev_q.pop_front() : 'x;
         check("event", {cpu_irq, cpu_irq & cpu_irq_sw, (cpu_irq & !cpu_irq_sw) ? cpu_irq_src : 5'h00,
                          src_flag_clr}, e_v);
      end
      cyc++;
      if (cyc > 20000) begin
         failures++;
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // Stimulus tasks
   // ---------------------------------------------------------------
   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic reg_read(input logic [2:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic put(input logic [23:0] a, input logic [31:0] v, input int n);
      for (int k = 0; k < n; k++) u_mem.mem[int'(a) + k] = v[8*k +: 8];
   endtask

   function automatic logic [23:0] nxt(input logic [23:0] a, input logic [1:0] m, input logic [23:0] n);
      return (m == STEP_INC) ? a + n : (m == STEP_DEC) ? a - n : a;
   endfunction

   task automatic vec(input logic [15:0] va, input logic [23:0] p);
      put({8'h00, va}, {8'h00, p}, 2);
      cmd_q.push_back(exp_cmd_t'{1'b0, {8'h00, va}, 32'h0, 32'h0});
   endtask

   // Count word B carries a marker that must come back untouched.
   task automatic svc(input logic [23:0] p, input logic [7:0] ma, input logic [7:0] mb, input logic [15:0] ca,
                      input logic [15:0] dat);
      logic [23:0] s;
      logic [23:0] d;
      logic [23:0] n;
      logic [31:0] mk;
      s  = 24'h001000 + {12'h0, p[11:0]};
      d  = 24'h002000 + {12'h0, p[11:0]};
      n  = ma[MA_SIZE] ? 24'h2 : 24'h1;
      mk = ma[MA_SIZE] ? 32'hFFFF : 32'hFF;
      put(p, {ma, s}, 4);
      put(p + 24'h4, {mb, d}, 4);
      put(p + 24'h8, {ca, 16'h5A3C}, 4);
      put(s, {16'h0, dat}, 2);
      for (int k = 0; k < 3; k++) cmd_q.push_back(exp_cmd_t'{1'b0, p + 24'(4 * k), 32'h0, 32'h0});
      cmd_q.push_back(exp_cmd_t'{1'b0, s, 32'h0, 32'h0});
      cmd_q.push_back(exp_cmd_t'{1'b1, d, {16'h0, dat} & mk, mk});
      cmd_q.push_back(exp_cmd_t'{1'b1, p, {ma, nxt(s, ma[7:6], n)}, 32'hFFFFFFFF});
      cmd_q.push_back(exp_cmd_t'{1'b1, p + 24'h4, {mb, nxt(d, ma[5:4], n)}, 32'hFFFFFFFF});
      cmd_q.push_back(exp_cmd_t'{1'b1, p + 24'h8, {ca - 16'h1, 16'h5A3C}, 32'hFFFFFFFF});
   endtask

   task automatic src_svc(input int i, input logic [7:0] ma, input logic [7:0] mb, input logic [15:0] ca);
      logic [23:0] p;
      p = 24'hFFF800 + 24'(i * 16);
      reg_write(3'(1 + en_pos[i] / 8), 8'(1 << (en_pos[i] % 8)));
      vec(16'h0400 + 16'(vec_num[i] * 2), p);
      svc(p, ma, mb, ca, 16'($urandom));
      ev_q.push_back((ca == 16'h1 || mb[MB_PER_TRANSFER_INTERRUPT_SELECT]) ? {2'b10, 5'(i), 27'h0} : {7'h0, 27'(1) << i});
   endtask

   task automatic wait_quiet();
      for (int k = 0; k < 400 && (cmd_q.size() != 0 || ev_q.size() != 0); k++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [6:0] swv;
      int         kind;
      rstn      = 1'b0;
      reg_addr  = 3'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      flag_set  = '0;
      failures  = 0;
      checks    = 0;
      cyc       = 0;
      cmd_on    = 1'b1;
      rd_d      = 1'b0;
      void'($urandom(90));
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (int a = 0; a < 8; a++) reg_read(3'(a), 8'h00);
      reg_write(REG_STATUS, 8'hFF);
      reg_read(REG_STATUS, 8'h00);
      // Software chain plus two sources pending together: software first, then ascending vector.
      swv = 7'($urandom);
      vec(16'h0400 + {8'h00, swv, 1'b0}, 24'hFFFB00);
      svc(24'hFFFB00, 8'($urandom) & 8'hF1, 8'h80, 16'h1, 16'($urandom));
      svc(24'hFFFB0C, 8'($urandom) & 8'hF1, 8'h00, 16'h3, 16'($urandom));
      src_svc(5, 8'hA1, 8'h00, 16'h2);
      src_svc(26, 8'hF0, 8'h00, 16'h2);
      flag_set <= (27'(1) << 5) | (27'(1) << 26);
      reg_write(REG_SWVEC, {1'b1, swv});
      flag_set <= '0;
      wait_quiet();
      reg_read(REG_SWVEC, {1'b0, swv});
      for (int i = 0; i < NSRC; i++) begin
         kind = $urandom_range(2);
         src_svc(i, 8'($urandom) & 8'hF1, kind == 2 ? 8'h40 : 8'h00,
                 kind == 1 ? 16'h1 : kind == 2 ? 16'h5 : (i % 4 == 0 ? 16'h0 : 16'h2));
         flag_set <= 27'(1) << i;
         @(posedge core_clk);
         flag_set <= '0;
         wait_quiet();
         reg_read(3'(1 + en_pos[i] / 8), kind == 0 ? 8'(1 << (en_pos[i] % 8)) : 8'h00);
      end
      // Ended software service keeps its enable set, so a rerun may follow; commands stop being watched.
      swv = 7'($urandom);
      vec(16'h0400 + {8'h00, swv, 1'b0}, 24'hFFFB40);
      svc(24'hFFFB40, 8'($urandom) & 8'hF1, 8'h00, 16'h1, 16'($urandom));
      ev_q.push_back({2'b11, 5'h00, 27'h0});
      reg_write(REG_SWVEC, {1'b1, swv});
      for (int k = 0; k < 400 && cmd_q.size() != 0; k++) @(posedge core_clk);
      cmd_on = 1'b0;
      for (int k = 0; k < 20 && ev_q.size() != 0; k++) @(posedge core_clk);
      reg_read(REG_SWVEC, {1'b1, swv});
      @(posedge core_clk);
      check("queues_left", 64'(cmd_q.size() + ev_q.size() + rd_q.size()), 64'h0);
      end_sim();
   end
endmodule
